// ==== src/special_page_pkg.sv ====
/*
   constants, field layouts and types shared by the special register page stack.
   assumes a single 100 MHz core clock and synchronous active-low reset.
*/
package special_page_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // address space
   localparam int unsigned AXI_ADDR_W     = 10;
   localparam logic [7:0]  SPECIAL_BASE   = 8'h80;
   localparam logic [7:0]  ADDR_PAGE_CTRL = 8'h84;
   localparam logic [7:0]  ADDR_CUR_PAGE  = 8'ha7;
   localparam logic [7:0]  ADDR_MID_SLOT  = 8'h85;
   localparam logic [7:0]  ADDR_BOT_SLOT  = 8'h86;
   localparam logic [7:0]  STATUS_INDEX   = 8'h00;
   localparam logic [2:0]  BIT_ADDR_LOW   = 3'h0;
   localparam logic [7:0]  PORT_ADDRS [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};

   ////////////////////////////////////////////////////////////////////////////
   // pages and reset values
   localparam logic [7:0]  PAGE_ZERO      = 8'h00;
   localparam logic [7:0]  PAGE_CAN       = 8'h0c;
   localparam logic [7:0]  PAGE_CFG       = 8'h0f;
   localparam logic [7:0]  PAGE_HIGH      = 8'h10;
   localparam logic [7:0]  PAGE_RESET     = 8'h00;
   localparam logic [7:0]  SLOT_EMPTY     = 8'h00;
   localparam logic        AUTO_EN_RESET  = 1'b1;
   localparam int unsigned AUTO_EN_BIT    = 0;
   localparam logic [2:0]  STATUS_RESET   = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // bus answers
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // register selected by a decoded access
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_CTRL = 3'b001,
      SEL_CUR  = 3'b010,
      SEL_MID  = 3'b011,
      SEL_BOT  = 3'b100
   } reg_sel_t;

   // interrupting source kinds
   typedef enum logic [2:0] {
      SRC_OTHER              = 3'b000,
      SRC_CAN_CONTROLLER     = 3'b001,
      SRC_SECOND_UART        = 3'b010,
      SRC_COUNTER_ARRAY_ONE  = 3'b011,
      SRC_THIRD_COMPARATOR   = 3'b100,
      SRC_FOURTH_FIFTH_TIMER = 3'b101
   } int_src_t;

endpackage

// ==== src/page_decode.sv ====
/*
   decodes one special register address against the current page.
   assumes a stable address and page; purely combinational.
*/
module page_decode
   import special_page_pkg::*;
(
   // access
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_page,
   // decode results
   output reg_sel_t        o_sel,
   output logic            o_bit_ok,
   output logic            o_all_pages,
   output logic            o_page_populated
);

   // registers of this block; the stack lives on every page
   always_comb begin
      o_sel = SEL_NONE;
      unique case (i_addr)
         ADDR_CUR_PAGE: o_sel = SEL_CUR;
         ADDR_MID_SLOT: o_sel = SEL_MID;
         ADDR_BOT_SLOT: o_sel = SEL_BOT;
         ADDR_PAGE_CTRL: begin
            if (i_page == PAGE_CFG) begin
               o_sel = SEL_CTRL;
            end
         end
         default: o_sel = SEL_NONE;
      endcase
   end

   // bit access only where low three bits are zero
   assign o_bit_ok = (i_addr[2:0] == BIT_ADDR_LOW);

   // port registers ignore the page
   always_comb begin
      o_all_pages = 1'b0;
      for (int k = 0; k < 4; k++) begin
         if (i_addr == PORT_ADDRS[k]) begin
            o_all_pages = 1'b1;
         end
      end
   end

   // only three pages carry registers
   assign o_page_populated = (i_page == PAGE_ZERO) || (i_page == PAGE_CAN)
                           || (i_page == PAGE_CFG);

endmodule // page_decode

// ==== src/int_page_map.sv ====
/*
   maps an interrupting source to the page loaded on entry.
   assumes the source code is valid while the entry pulse is high.
*/
module int_page_map
   import special_page_pkg::*;
(
   // source
   input  int_src_t   i_source,
   // page to load
   output logic [7:0] o_page
);

   // per source entry page
   always_comb begin
      unique case (i_source)
         SRC_CAN_CONTROLLER:     o_page = PAGE_CAN;
         SRC_SECOND_UART,
         SRC_COUNTER_ARRAY_ONE,
         SRC_THIRD_COMPARATOR,
         SRC_FOURTH_FIFTH_TIMER: o_page = PAGE_HIGH;
         SRC_OTHER:              o_page = PAGE_ZERO;
         default:                o_page = PAGE_ZERO;
      endcase
   end

endmodule // int_page_map

// ==== src/special_register_page_stack.sv ====
/*
   special register space decoding, page selection and the three-byte page stack,
   with the stack and control registers reachable both from the core's direct
   accesses and from an AXI4-Lite slave.
   assumes the core drives one-cycle entry and return pulses on i_core_clk and
   that peripherals outside respond to o_periph_sel.
*/
module special_register_page_stack
   import special_page_pkg::*;
(
   // clock and reset
   input  wire logic                  i_core_clk,
   input  wire logic                  i_reset_n,
   // axi4-lite write address
   input  wire logic [AXI_ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic                  i_s_axi_awvalid,
   output logic                       o_s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]           i_s_axi_wdata,
   input  wire logic [3:0]            i_s_axi_wstrb,
   input  wire logic                  i_s_axi_wvalid,
   output logic                       o_s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                 o_s_axi_bresp,
   output logic                       o_s_axi_bvalid,
   input  wire logic                  i_s_axi_bready,
   // axi4-lite read address
   input  wire logic [AXI_ADDR_W-1:0] i_s_axi_araddr,
   input  wire logic                  i_s_axi_arvalid,
   output logic                       o_s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                o_s_axi_rdata,
   output logic [1:0]                 o_s_axi_rresp,
   output logic                       o_s_axi_rvalid,
   input  wire logic                  i_s_axi_rready,
   // core direct access
   input  wire logic                  i_dir_valid,
   input  wire logic [7:0]            i_dir_addr,
   input  wire logic                  i_dir_write,
   input  wire logic                  i_dir_bit,
   input  wire logic [2:0]            i_dir_bitpos,
   input  wire logic [7:0]            i_dir_wdata,
   // core direct answer
   output logic [7:0]                 o_dir_rdata,
   output logic                       o_dir_rvalid,
   output logic                       o_dir_special,
   output logic                       o_dir_bit_refused,
   // peripheral side
   output logic                       o_periph_sel,
   output logic                       o_periph_all_pages,
   output logic [7:0]                 o_periph_page,
   // core interrupt events
   input  wire logic                  i_int_enter,
   input  int_src_t                   i_int_source,
   input  wire logic                  i_int_return,
   // state
   output logic [7:0]                 o_current_page,
   output logic                       o_auto_page_enable
);

   ////////////////////////////////////////////////////////////////////////////
   // state and decode signals

   logic [7:0]            current_page_reg_r;
   logic [7:0]            middle_page_slot_r;
   logic [7:0]            bottom_page_slot_r;
   logic                  auto_page_enable_r;
   logic [2:0]            status_r;
   logic [7:0]            dir_rdata_r;
   logic                  dir_rvalid_r;
   logic                  aw_full_r;
   logic [AXI_ADDR_W-1:0] aw_addr_r;
   logic                  w_full_r;
   logic [7:0]            w_data_r;
   logic                  w_lane0_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  rvalid_r;
   logic [1:0]            rresp_r;
   logic [31:0]           rdata_r;

   reg_sel_t              core_sel;
   logic                  core_bit_ok;
   logic                  core_all_pages;
   logic                  core_populated;
   reg_sel_t              aw_sel;
   reg_sel_t              ar_sel;
   logic [7:0]            aw_index;
   logic [7:0]            ar_index;
   logic [7:0]            int_page;
   logic                  core_special;
   logic                  core_bit_refused;
   logic                  core_wr;
   logic [7:0]            core_old;
   logic [7:0]            core_wdata;
   logic                  axi_wr_go;
   logic                  axi_wr_do;
   logic                  axi_wr_bad;
   logic                  ar_take;
   logic                  ar_bad;
   reg_sel_t              sw_sel;
   logic [7:0]            sw_data;
   logic                  push;
   logic                  pop;

   ////////////////////////////////////////////////////////////////////////////
   // decoders and source page lookup

   // core direct access decode under the current page
   page_decode u_core_decode (
      .i_addr           (i_dir_addr),
      .i_page           (current_page_reg_r),
      .o_sel            (core_sel),
      .o_bit_ok         (core_bit_ok),
      .o_all_pages      (core_all_pages),
      .o_page_populated (core_populated)
   );

   // bus indices are byte address over four
   assign aw_index = aw_addr_r[9:2];
   assign ar_index = i_s_axi_araddr[9:2];

   page_decode u_aw_decode (
      .i_addr           (aw_index),
      .i_page           (current_page_reg_r),
      .o_sel            (aw_sel),
      .o_bit_ok         (),
      .o_all_pages      (),
      .o_page_populated ()
   );

   page_decode u_ar_decode (
      .i_addr           (ar_index),
      .i_page           (current_page_reg_r),
      .o_sel            (ar_sel),
      .o_bit_ok         (),
      .o_all_pages      (),
      .o_page_populated ()
   );

   int_page_map u_int_page (
      .i_source (i_int_source),
      .o_page   (int_page)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register read value

   // reserved control bits read as zero
   function automatic logic [7:0] reg_value(input reg_sel_t sel);
      logic [7:0] v;
      v = 8'h00;
      unique case (sel)
         SEL_CTRL: v[AUTO_EN_BIT] = auto_page_enable_r;
         SEL_CUR:  v = current_page_reg_r;
         SEL_MID:  v = middle_page_slot_r;
         SEL_BOT:  v = bottom_page_slot_r;
         SEL_NONE: v = 8'h00;
         default:  v = 8'h00;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // core direct access

   // upper half of direct space is special registers
   assign core_special     = i_dir_valid && (i_dir_addr >= SPECIAL_BASE);
   assign core_bit_refused = core_special && i_dir_bit && !core_bit_ok;
   assign core_wr = core_special && i_dir_write && (core_sel != SEL_NONE)
                  && !core_bit_refused;
   always_comb core_old = reg_value(core_sel);

   // bit writes merge one bit into the old byte
   always_comb begin
      core_wdata = i_dir_wdata;
      if (i_dir_bit) begin
         core_wdata = core_old;
         core_wdata[i_dir_bitpos] = i_dir_wdata[0];
      end
   end

   // peripherals answer the rest of special space
   assign o_periph_sel       = core_special && (core_sel == SEL_NONE)
                             && !core_bit_refused;
   assign o_periph_all_pages = core_all_pages;
   assign o_periph_page      = current_page_reg_r;
   assign o_dir_special      = core_special;
   assign o_dir_bit_refused  = core_bit_refused;

   // read data one cycle after the request
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         dir_rdata_r  <= 8'h00;
         dir_rvalid_r <= 1'b0;
      end else begin
         dir_rvalid_r <= core_special && !i_dir_write && !core_bit_refused;
         if (core_special && !i_dir_write) begin
            dir_rdata_r <= core_old;
         end
      end
   end

   assign o_dir_rdata  = dir_rdata_r;
   assign o_dir_rvalid = dir_rvalid_r;

   // last access status for software
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         status_r <= STATUS_RESET;
      end else if (i_dir_valid) begin
         status_r <= {core_populated, core_bit_refused, core_special};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write path

   assign o_s_axi_awready = !aw_full_r;
   assign o_s_axi_wready  = !w_full_r;

   // core writes win the cycle; the bus write waits one more
   assign axi_wr_go  = aw_full_r && w_full_r && !bvalid_r && !core_wr;
   assign axi_wr_bad = (aw_sel == SEL_NONE) && (aw_index != STATUS_INDEX);
   assign axi_wr_do  = axi_wr_go && (aw_sel != SEL_NONE) && w_lane0_r;

   // address and data held until both arrived
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= '0;
         w_full_r  <= 1'b0;
         w_data_r  <= 8'h00;
         w_lane0_r <= 1'b0;
      end else begin
         if (i_s_axi_awvalid && !aw_full_r) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= i_s_axi_awaddr;
         end else if (axi_wr_go) begin
            aw_full_r <= 1'b0;
         end
         if (i_s_axi_wvalid && !w_full_r) begin
            w_full_r  <= 1'b1;
            w_data_r  <= i_s_axi_wdata[7:0];
            w_lane0_r <= i_s_axi_wstrb[0];
         end else if (axi_wr_go) begin
            w_full_r <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (axi_wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= axi_wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (i_s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign o_s_axi_bvalid = bvalid_r;
   assign o_s_axi_bresp  = bresp_r;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read path

   assign o_s_axi_arready = !rvalid_r;
   assign ar_take = i_s_axi_arvalid && !rvalid_r;
   assign ar_bad  = (ar_sel == SEL_NONE) && (ar_index != STATUS_INDEX);

   // one read at a time, answered the cycle after it is taken
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rresp_r  <= ar_bad ? RESP_SLVERR : RESP_OKAY;
         if (ar_index == STATUS_INDEX) begin
            rdata_r <= {29'h0000_0000, status_r};
         end else begin
            rdata_r <= {24'h00_0000, reg_value(ar_sel)};
         end
      end else if (i_s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign o_s_axi_rvalid = rvalid_r;
   assign o_s_axi_rresp  = rresp_r;
   assign o_s_axi_rdata  = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // software write merge

   // core direct writes take priority over the bus
   always_comb begin
      sw_sel  = SEL_NONE;
      sw_data = 8'h00;
      if (core_wr) begin
         sw_sel  = core_sel;
         sw_data = core_wdata;
      end else if (axi_wr_do) begin
         sw_sel  = aw_sel;
         sw_data = w_data_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page control

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         auto_page_enable_r <= AUTO_EN_RESET;
      end else if (sw_sel == SEL_CTRL) begin
         auto_page_enable_r <= sw_data[AUTO_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page stack

   // entry wins over a return in the same cycle; both need the enable
   assign push = i_int_enter && auto_page_enable_r;
   assign pop  = i_int_return && !i_int_enter && auto_page_enable_r;

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         current_page_reg_r <= PAGE_RESET;
         middle_page_slot_r <= PAGE_RESET;
         bottom_page_slot_r <= PAGE_RESET;
      end else if (push) begin
         current_page_reg_r <= int_page;
         middle_page_slot_r <= current_page_reg_r;
         bottom_page_slot_r <= middle_page_slot_r;
      end else if (pop) begin
         current_page_reg_r <= middle_page_slot_r;
         middle_page_slot_r <= bottom_page_slot_r;
         bottom_page_slot_r <= SLOT_EMPTY;
      end else begin
         // plain stores, never a push or pop
         unique case (sw_sel)
            SEL_CUR: current_page_reg_r <= sw_data;
            SEL_MID: middle_page_slot_r <= sw_data;
            SEL_BOT: bottom_page_slot_r <= sw_data;
            SEL_CTRL,
            SEL_NONE: begin
            end
            default: begin
            end
         endcase
      end
   end

   assign o_current_page     = current_page_reg_r;
   assign o_auto_page_enable = auto_page_enable_r;

endmodule // special_register_page_stack

// ==== bench/special_page_monitor.sv ====
/*
   checker on the page stack top ports.
   assumes one clock and a synchronous active-low reset; bound to the top.
*/
module special_page_monitor
   import special_page_pkg::*;
(
   // clock and reset
   input wire logic       i_core_clk,
   input wire logic       i_reset_n,
   // core side
   input wire logic       i_dir_valid,
   input wire logic [7:0] i_dir_addr,
   input wire logic       i_dir_write,
   input wire logic       i_dir_bit,
   input wire logic [7:0] i_dir_wdata,
   input wire logic       i_int_enter,
   input int_src_t        i_int_source,
   input wire logic       i_int_return,
   // bus write side
   input wire logic       i_s_axi_awvalid,
   input wire logic       i_s_axi_wvalid,
   input wire logic       o_s_axi_awready,
   input wire logic       o_s_axi_wready,
   // watched outputs
   input wire logic       o_dir_special,
   input wire logic       o_dir_bit_refused,
   input wire logic [7:0] o_current_page,
   input wire logic       o_auto_page_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////
   // quiet: no core or bus write can land at the coming edge
   logic       quiet;
   logic [7:0] entry_page;
   assign quiet = !i_dir_valid && !i_s_axi_awvalid && !i_s_axi_wvalid &&
                  o_s_axi_awready && o_s_axi_wready;
   assign entry_page = (i_int_source == SRC_OTHER) ? 8'h00 :
                       (i_int_source == SRC_CAN_CONTROLLER) ? 8'h0c : 8'h10;
   // decode of each direct access
   special_space_a: assert property (i_dir_valid |-> o_dir_special == i_dir_addr[7])
      else $error("special space flag wrong");
   bit_refuse_a: assert property (i_dir_valid && i_dir_addr[7] && i_dir_bit |->
      o_dir_bit_refused == (i_dir_addr[2:0] != 3'h0)) else $error("bit refusal wrong");
   // stack movement
   push_page_a: assert property (i_int_enter && o_auto_page_enable |=>
      o_current_page == $past(entry_page)) else $error("entry page wrong");
   pop_page_a: assert property (i_int_enter && o_auto_page_enable && quiet ##1
      quiet && !i_int_enter && !i_int_return ##1 i_int_return && !i_int_enter && quiet
      |=> o_current_page == $past(o_current_page, 3)) else $error("return page wrong");
   hold_off_a: assert property (!o_auto_page_enable && quiet |=> $stable(o_current_page))
      else $error("page moved while disabled");
   reset_value_a: assert property ($rose(i_reset_n) |->
      o_current_page == 8'h00 && o_auto_page_enable) else $error("reset values wrong");
   // software writes
   page_write_a: assert property (i_dir_valid && i_dir_write && !i_dir_bit &&
      i_dir_addr == ADDR_CUR_PAGE && !i_int_enter && !i_int_return
      |=> o_current_page == $past(i_dir_wdata)) else $error("page write lost");
   ctrl_write_a: assert property (i_dir_valid && i_dir_write && !i_dir_bit &&
      i_dir_addr == ADDR_PAGE_CTRL && o_current_page == PAGE_CFG
      |=> o_auto_page_enable == $past(i_dir_wdata[0])) else $error("enable write lost");
endmodule // special_page_monitor

bind special_register_page_stack special_page_monitor special_page_monitor_i (
   .i_core_clk, .i_reset_n, .i_dir_valid, .i_dir_addr, .i_dir_write, .i_dir_bit,
   .i_dir_wdata, .i_int_enter, .i_int_source, .i_int_return, .i_s_axi_awvalid,
   .i_s_axi_wvalid, .o_s_axi_awready, .o_s_axi_wready, .o_dir_special,
   .o_dir_bit_refused, .o_current_page, .o_auto_page_enable);

// ==== bench/core_model.sv ====
/*
   behavioural processor core: direct access pulses and interrupt pulses.
   assumes the bench calls its tasks; signals change just after rising edges.
*/
module core_model
   import special_page_pkg::*;
(
   // clock
   input  wire logic i_core_clk,
   // direct access
   output logic       o_dir_valid,
   output logic [7:0] o_dir_addr,
   output logic       o_dir_write,
   output logic       o_dir_bit,
   output logic [2:0] o_dir_bitpos,
   output logic [7:0] o_dir_wdata,
   // interrupt events
   output logic       o_int_enter,
   output int_src_t   o_int_source,
   output logic       o_int_return
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////
   initial begin
      {o_dir_valid, o_dir_addr, o_dir_write, o_dir_bit, o_dir_bitpos, o_dir_wdata} = '0;
      {o_int_enter, o_int_return} = '0;
      o_int_source = SRC_OTHER;
   end
   // one access pulse; the caller selects the page first
   task automatic acc(input logic [7:0] a, input logic w, input logic b,
                      input logic [2:0] p, input logic [7:0] d);
      @(posedge i_core_clk);
      o_dir_valid  <= 1'b1;
      o_dir_addr   <= a;
      o_dir_write  <= w;
      o_dir_bit    <= b;
      o_dir_bitpos <= p;
      o_dir_wdata  <= d;
      @(posedge i_core_clk);
      o_dir_valid  <= 1'b0;
      o_dir_addr   <= ~a;
      o_dir_wdata  <= ~d;
   endtask
   // one-cycle entry or return pulse
   task automatic irq(input logic e, input logic r, input int_src_t s);
      @(posedge i_core_clk);
      o_int_enter  <= e;
      o_int_return <= r;
      o_int_source <= s;
      @(posedge i_core_clk);
      {o_int_enter, o_int_return} <= 2'h0;
      o_int_source <= int_src_t'(~s);
   endtask
endmodule // core_model

// ==== bench/testbench.sv ====
/*
   self-checking bench: core model, bus master tasks and a stack model.
   assumes the design's answer timing; 100 MHz clock.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import special_page_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [9:0] i_s_axi_awaddr, i_s_axi_araddr, pexp;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
   logic [3:0] i_s_axi_wstrb;
   logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
   logic i_dir_valid, i_dir_write, i_dir_bit, i_int_enter, i_int_return, o_auto_page_enable;
   logic [7:0] i_dir_addr, i_dir_wdata, o_dir_rdata, o_current_page, o_periph_page;
   logic [2:0] i_dir_bitpos;
   int_src_t i_int_source;
   logic o_dir_rvalid, o_dir_special, o_dir_bit_refused, o_periph_sel, o_periph_all_pages;
   int mismatches = 0, n_tests = 0, cur = 0, mid = 0, bot = 0, en = 1;
   logic [31:0] seed = 32'h0001786d;
   ////////////////////////////////////////////////////////////
   always #5 i_core_clk = ~i_core_clk;
   core_model core_i (.i_core_clk(i_core_clk), .o_dir_valid(i_dir_valid),
      .o_dir_addr(i_dir_addr), .o_dir_write(i_dir_write), .o_dir_bit(i_dir_bit),
      .o_dir_bitpos(i_dir_bitpos), .o_dir_wdata(i_dir_wdata), .o_int_enter(i_int_enter),
      .o_int_source(i_int_source), .o_int_return(i_int_return));
   special_register_page_stack special_register_page_stack_i (.*);
   // check, verdict, timeout
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic limit(input int n);
      if (n < 50) return;
      mismatches++;
      summarize();
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // reference stack model
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      core_i.acc(a, 1'b1, 1'b0, 3'h0, d);
      if (a == 8'ha7) cur = d;
      else if (a == 8'h85) mid = d;
      else if (a == 8'h86) bot = d;
      else if (a == 8'h84 && cur == 8'h0f) en = d[0];
   endtask
   task automatic evt(input logic e, input int_src_t s);
      core_i.irq(e, !e, s);
      if (en && e) begin
         bot = mid;
         mid = cur;
         cur = (s == SRC_OTHER) ? 8'h00 : (s == SRC_CAN_CONTROLLER) ? 8'h0c : 8'h10;
      end else if (en) begin
         cur = mid;
         mid = bot;
         bot = 8'h00;
      end
      #1 chk("page", o_current_page, cur);
   endtask
   task automatic stack();
      logic [7:0] adr [3] = '{8'ha7, 8'h85, 8'h86};
      int exp [3];
      exp = '{cur, mid, bot};
      for (int k = 0; k < 3; k++) begin
         core_i.acc(adr[k], 1'b0, 1'b0, 3'h0, 8'h00);
         #1 chk("stack byte", {o_dir_rvalid, o_dir_rdata}, {1'b1, exp[k][7:0]});
      end
   endtask
   // bus master
   task automatic axi_wr(input logic [9:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge i_core_clk);
      i_s_axi_awaddr  <= a;
      i_s_axi_wdata   <= {24'h000000, d};
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid  <= 1'b1;
      i_s_axi_bready  <= 1'b1;
      do begin
         @(posedge i_core_clk);
         n++;
         if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      end while (o_s_axi_bvalid !== 1'b1 && n < 50);
      i_s_axi_bready <= 1'b0;
      limit(n);
      chk("write resp", o_s_axi_bresp, 2'h0);
   endtask
   task automatic axi_rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
      int n = 0;
      @(posedge i_core_clk);
      i_s_axi_araddr  <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready  <= 1'b1;
      do begin
         @(posedge i_core_clk);
         n++;
         if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      end while (!(o_s_axi_rvalid === 1'b1 && !i_s_axi_arvalid) && n < 50);
      i_s_axi_rready <= 1'b0;
      limit(n);
      chk("read data", o_s_axi_rdata, e);
      chk("read resp", o_s_axi_rresp, r);
   endtask
   // peripheral side
   always @(negedge i_core_clk) if (i_dir_valid) begin
      pexp = {(i_dir_addr == 8'h84) ? cur != 8'h0f : !(i_dir_addr inside {8'ha7, 8'h85, 8'h86}),
         i_dir_addr == 8'h90, cur[7:0]};
      chk("periph", {o_periph_sel, o_periph_all_pages, o_periph_page}, pexp);
   end
   // main sequence
   initial begin
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_awvalid} = '0;
      {i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = '0;
      i_s_axi_wstrb = 4'hf;
      repeat (16) @(posedge i_core_clk);
      i_reset_n <= 1'b1;
      @(posedge i_core_clk);
      #1 chk("auto enable", o_auto_page_enable, 1'b1);
      stack();
      for (int s = 0; s < 6; s++) begin
         seed = lfsr(seed);
         wr(8'ha7, seed[7:0]);
         evt(1'b1, int_src_t'(s));
         wr(8'h86, seed[15:8]);
         stack();
         evt(1'b0, SRC_OTHER);
      end
      evt(1'b1, SRC_SECOND_UART);
      evt(1'b0, SRC_OTHER);
      wr(8'ha7, 8'h00);
      evt(1'b1, SRC_CAN_CONTROLLER);
      wr(8'h86, 8'h5a);
      evt(1'b1, SRC_COUNTER_ARRAY_ONE);
      stack();
      wr(8'h85, 8'h0f);
      evt(1'b0, SRC_OTHER);
      evt(1'b0, SRC_OTHER);
      stack();
      wr(8'ha7, 8'h0f);
      wr(8'h84, 8'h00);
      evt(1'b1, SRC_CAN_CONTROLLER);
      evt(1'b0, SRC_OTHER);
      wr(8'h84, 8'h01);
      wr(8'ha7, 8'h00);
      wr(8'h84, 8'h00);
      wr(8'h90, 8'h55);
      #1 chk("auto enable", o_auto_page_enable, en);
      core_i.acc(8'h86, 1'b1, 1'b1, 3'h2, 8'h01);
      stack();
      seed = lfsr(seed);
      axi_wr(10'h29c, seed[7:0]);
      cur = seed[7:0];
      axi_rd(10'h29c, cur, 2'h0);
      axi_rd(10'h214, mid, 2'h0);
      axi_rd(10'h004, 32'h00000000, 2'h2);
      axi_wr(10'h29c, 8'h0f);
      cur = 8'h0f;
      axi_wr(10'h210, 8'h00);
      en = 0;
      evt(1'b1, SRC_SECOND_UART);
      summarize();
   end
endmodule // testbench
